// ### rtl/eps_supervisor.sv
/*
  Programmer supervisor: command sequencing for read, program and verify,
  supply supervision, page filtering of downloaded records, upload address
  forming and device type and algorithm selection.
  Assumes commands arrive as one-cycle pulses from a command decoder, the
  socket drivers report pass results, and conversions are always current.
*/
// Notes on behaviour
// - Excessive pre-regulator voltage: panic, abandon operation.
// - Pre-regulator limits follow read or program level.
// - Reading: both supplies near 5 V, else error.
// - Reading: low pre-regulator recoverable, high panics.
// - Programming: supplies near 48 V and 60 V.
// - Programming: high panics, low recoverable error.
// - After every operation, all supplies near zero.
// - Record address: page high byte, offset low.
// - Automatic page taken from first record's page.
// - Reset starts in automatic page mode.
// - Records from other pages are discarded.
// - Report count of accepted records after download.
// - Upload page is selected page, else 00.
// - Type defaults newer; 1 older, 0 newer.
// - Type change resets algorithm: adaptive or ten.
// - Adaptive: count passes P, then add 4P.
// - Count zero adaptive; nonzero exact pass count.
// - Confirm before programming; verify contents afterwards.
// - Blank read fills buffer with type's erased value.
// - Only upper 8 conversion bits are compared.
// - Supply is off at or below 01.
// - High positive supply accepted from 8E to 9C.
module eps_supervisor
  import eps_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // Configuration commands.
  input  wire logic             page_select_command_i,
  input  wire logic             page_auto_i,
  input  wire logic [7:0]       page_value_i,
  input  wire logic             device_type_command_i,
  input  wire logic             device_type_i,
  input  wire logic             pass_count_command_i,
  input  wire logic [7:0]       pass_count_i,
  // Operation commands.
  input  wire logic             socket_read_command_i,
  input  wire logic             socket_program_command_i,
  input  wire logic             confirm_yes_i,
  input  wire logic             confirm_no_i,
  input  wire logic             err_continue_i,
  input  wire logic             err_abort_i,
  // Download records.
  input  wire logic             download_start_i,
  input  wire logic             record_valid_i,
  input  wire logic [15:0]      record_addr_i,
  input  wire logic             download_end_i,
  // Upload address forming.
  input  wire logic [7:0]       upload_offset_i,
  // Socket driver handshakes.
  input  wire logic             pass_done_i,
  input  wire logic             readback_ok_i,
  input  wire logic             verify_done_i,
  input  wire logic             verify_match_i,
  // Conversion results.
  input  wire logic [ADC_W-1:0] pre_adc_i,
  input  wire logic [ADC_W-1:0] vcc_adc_i,
  input  wire logic [ADC_W-1:0] vbb_adc_i,
  // Outputs.
  output logic                  record_write_o,
  output logic [7:0]            record_offset_o,
  output logic [7:0]            accepted_count_o,
  output logic                  download_report_o,
  output logic [15:0]           upload_addr_o,
  output logic                  device_older_o,
  output logic [7:0]            pass_setting_o,
  output logic [7:0]            erased_value_o,
  output logic                  socket_power_o,
  output logic                  high_voltage_o,
  output logic                  pass_start_o,
  output logic                  verify_start_o,
  output logic                  confirm_request_o,
  output logic                  error_pending_o,
  output logic                  off_error_o,
  output logic                  panic_o,
  output logic                  verify_match_o,
  output logic                  op_done_o,
  output logic                  busy_o
);

  typedef struct packed {
    eps_state_e state;
    logic       page_auto;
    logic       page_known;
    logic [7:0] page;
    logic       older;
    logic [7:0] passes;
    logic [7:0] pass_cnt;
    logic [9:0] over_left;
    logic [7:0] acc_cnt;
    logic       in_download;
    logic       rec_wr;
    logic [7:0] rec_off;
    logic       dl_report;
    logic       power;
    logic       hv;
    logic       pass_go;
    logic       verify_go;
    logic       err;
    logic       waive;
    logic       off_err;
    logic       panic;
    logic       match;
    logic       done;
    eps_state_e resume;
  } eps_s;

  eps_s r;
  eps_s next_r;

  logic [1:0] vmode;
  logic       v_panic;
  logic       v_low;
  logic       v_off;

  always_comb begin
    unique case (r.state)
      EPS_READ:                                vmode = 2'(EPS_MODE_READ);
      EPS_PROG_PASS, EPS_PROG_CHECK,
      EPS_OVERPROG:                            vmode = 2'(EPS_MODE_PROG);
      EPS_FINISH:                              vmode = 2'(EPS_MODE_DONE);
      default:                                 vmode = 2'(EPS_MODE_IDLE);
    endcase
  end

  eps_volt_check u_vchk (
    .mode_i    (vmode),
    .pre_adc_i (pre_adc_i),
    .vcc_adc_i (vcc_adc_i),
    .vbb_adc_i (vbb_adc_i),
    .panic_o   (v_panic),
    .low_err_o (v_low),
    .off_err_o (v_off)
  );

  always_comb begin
    next_r           = r;
    next_r.rec_wr    = 1'b0;
    next_r.dl_report = 1'b0;
    next_r.pass_go   = 1'b0;
    next_r.verify_go = 1'b0;
    next_r.done      = 1'b0;
    if (page_select_command_i) begin
      next_r.page_auto  = page_auto_i;
      next_r.page       = page_value_i;
      next_r.page_known = !page_auto_i;
    end
    if (device_type_command_i) begin
      next_r.older  = device_type_i;
      next_r.passes = device_type_i ? LEGACY_PASSES : 8'h00;
    end
    if (pass_count_command_i) begin
      next_r.passes = pass_count_i;
    end

    // Download filtering; automatic mode relearns the page per file.
    if (download_start_i) begin
      next_r.in_download = 1'b1;
      next_r.acc_cnt     = 8'h00;
      next_r.page_known  = !r.page_auto;
    end
    if (r.in_download && record_valid_i) begin
      if (!r.page_known) begin
        next_r.page       = record_addr_i[15:8];
        next_r.page_known = 1'b1;
        next_r.rec_wr     = 1'b1;
        next_r.rec_off    = record_addr_i[7:0];
        next_r.acc_cnt    = r.acc_cnt + 8'h01;
      end else if (record_addr_i[15:8] == r.page) begin
        next_r.rec_wr  = 1'b1;
        next_r.rec_off = record_addr_i[7:0];
        next_r.acc_cnt = r.acc_cnt + 8'h01;
      end
    end
    if (r.in_download && download_end_i) begin
      next_r.in_download = 1'b0;
      next_r.dl_report   = 1'b1;
    end

    unique case (r.state)
      EPS_IDLE: begin
        if (socket_read_command_i) begin
          next_r.state = EPS_READ;
          next_r.power = 1'b1;
          next_r.err   = 1'b0;
        end else if (socket_program_command_i) begin
          next_r.state = EPS_CONFIRM;
          next_r.match = 1'b0;
        end
      end
      EPS_CONFIRM: begin
        if (confirm_yes_i) begin
          next_r.state    = EPS_PROG_PASS;
          next_r.power    = 1'b1;
          next_r.hv       = 1'b1;
          next_r.pass_cnt = 8'h00;
          next_r.pass_go  = 1'b1;
        end else if (confirm_no_i) begin
          next_r.state = EPS_IDLE;
        end
      end
      EPS_READ: begin
        if (verify_done_i) begin
          next_r.state = EPS_FINISH;
          next_r.power = 1'b0;
        end
      end
      EPS_PROG_PASS: begin
        if (pass_done_i) begin
          next_r.pass_cnt = r.pass_cnt + 8'h01;
          next_r.state    = EPS_PROG_CHECK;
        end
      end
      EPS_PROG_CHECK: begin
        if (r.passes == 8'h00 && readback_ok_i) begin
          // Over-programming runs four times the observed pass count.
          next_r.over_left = {2'b00, r.pass_cnt} * 10'(OVERPROG_MUL);
          next_r.state     = EPS_OVERPROG;
          next_r.pass_go   = 1'b1;
        end else if (r.passes != 8'h00 && r.pass_cnt >= r.passes) begin
          next_r.state     = EPS_VERIFY;
          next_r.hv        = 1'b0;
          next_r.verify_go = 1'b1;
        end else begin
          next_r.state   = EPS_PROG_PASS;
          next_r.pass_go = 1'b1;
        end
      end
      EPS_OVERPROG: begin
        if (pass_done_i) begin
          next_r.over_left = r.over_left - 10'h001;
          if (r.over_left == 10'h001) begin
            next_r.state     = EPS_VERIFY;
            next_r.hv        = 1'b0;
            next_r.verify_go = 1'b1;
          end else begin
            next_r.pass_go = 1'b1;
          end
        end
      end
      EPS_VERIFY: begin
        if (verify_done_i) begin
          next_r.match = verify_match_i;
          next_r.state = EPS_FINISH;
          next_r.power = 1'b0;
        end
      end
      EPS_ERR_WAIT: begin
        if (err_abort_i) begin
          next_r.power = 1'b0;
          next_r.hv    = 1'b0;
          next_r.err   = 1'b0;
          next_r.state = EPS_FINISH;
        end else if (err_continue_i) begin
          next_r.err   = 1'b0;
          next_r.waive = 1'b1;
          next_r.state = r.resume;
        end
      end
      EPS_FINISH: begin
        next_r.off_err = v_off;
        next_r.waive  = 1'b0;
        next_r.done    = 1'b1;
        next_r.state   = EPS_IDLE;
      end
      EPS_PANIC: begin
        next_r.power = 1'b0;
        next_r.hv    = 1'b0;
      end
    endcase

    // Supervision runs in live phases; a continued error waives low readings.
    if (vmode != 2'(EPS_MODE_IDLE) && vmode != 2'(EPS_MODE_DONE)) begin
      if (v_panic) begin
        next_r.state     = EPS_PANIC;
        next_r.panic     = 1'b1;
        next_r.power     = 1'b0;
        next_r.hv        = 1'b0;
        next_r.pass_go   = 1'b0;
        next_r.verify_go = 1'b0;
      end else if (v_low && !r.err && !r.waive) begin
        next_r.err     = 1'b1;
        next_r.resume  = r.state;
        next_r.state   = EPS_ERR_WAIT;
        next_r.pass_go = 1'b0;
      end
    end
    if (r.panic) begin
      next_r.state = EPS_PANIC;
      next_r.power = 1'b0;
      next_r.hv    = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r           <= '0;
      r.state     <= EPS_IDLE;
      r.resume    <= EPS_IDLE;
      r.page_auto <= 1'b1;
      r.older     <= TYPE_NEWER[0];
      r.passes    <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  assign record_write_o    = r.rec_wr;
  assign record_offset_o   = r.rec_off;
  assign accepted_count_o  = r.acc_cnt;
  assign download_report_o = r.dl_report;
  assign upload_addr_o     = {(r.page_auto ? PAGE_AUTO_UP : r.page),
                              upload_offset_i};
  assign device_older_o    = r.older;
  assign pass_setting_o    = r.passes;
  assign erased_value_o    = r.older ? ERASED_OLD : ERASED_NEW;
  assign socket_power_o    = r.power;
  assign high_voltage_o    = r.hv;
  assign pass_start_o      = r.pass_go;
  assign verify_start_o    = r.verify_go;
  assign confirm_request_o = (r.state == EPS_CONFIRM);
  assign error_pending_o   = r.err;
  assign off_error_o       = r.off_err;
  assign panic_o           = r.panic;
  assign verify_match_o    = r.match;
  assign op_done_o         = r.done;
  assign busy_o            = (r.state != EPS_IDLE) && (r.state != EPS_PANIC);

endmodule

// ### include/eps_pkg.sv
/*
  Constants and types shared by the programmer supervisor block.
  Assumes a single 40 MHz clock and a synchronous active-high reset.
*/
package eps_pkg;

  // Voltage limits are compared against the upper 8 bits of each conversion.
  localparam logic [7:0] OFF_MAX       = 8'h01;
  localparam logic [7:0] LV_MIN        = 8'h0E;
  localparam logic [7:0] LV_MAX        = 8'h11;
  localparam logic [7:0] PRE_LV_MIN    = 8'h28;
  localparam logic [7:0] PRE_LV_MAX    = 8'h38;
  localparam logic [7:0] VCC_HV_MIN    = 8'h8E;
  localparam logic [7:0] VCC_HV_MAX    = 8'h9C;
  localparam logic [7:0] VBB_HV_MIN    = 8'hAF;
  localparam logic [7:0] VBB_HV_MAX    = 8'hC3;
  localparam logic [7:0] PRE_HV_MIN    = 8'hD0;
  localparam logic [7:0] PRE_HV_MAX    = 8'hF0;

  localparam int         ADC_W         = 10;
  localparam logic [7:0] LEGACY_PASSES = 8'h0A;
  localparam logic [7:0] PAGE_AUTO_UP  = 8'h00;
  localparam logic [7:0] ERASED_NEW    = 8'hFF;
  localparam logic [7:0] ERASED_OLD    = 8'h00;
  localparam logic [2:0] OVERPROG_MUL  = 3'h4;
  localparam logic [1:0] TYPE_NEWER    = 2'h0;

  typedef enum logic [1:0] {
    EPS_MODE_IDLE,
    EPS_MODE_READ,
    EPS_MODE_PROG,
    EPS_MODE_DONE
  } eps_mode_e;

  typedef enum logic [3:0] {
    EPS_IDLE,
    EPS_READ,
    EPS_CONFIRM,
    EPS_PROG_PASS,
    EPS_PROG_CHECK,
    EPS_OVERPROG,
    EPS_VERIFY,
    EPS_ERR_WAIT,
    EPS_FINISH,
    EPS_PANIC
  } eps_state_e;

  // Classification of one supply against a low/high window.
  typedef enum logic [1:0] {
    EPS_V_OK,
    EPS_V_LOW,
    EPS_V_HIGH
  } eps_vclass_e;

endpackage

// ### rtl/eps_volt_check.sv
/*
  Voltage supervisor: classifies the three supplies against the limits of
  the active operation phase.
  Assumes the conversion results are held stable by the surrounding logic.
*/
module eps_volt_check
  import eps_pkg::*;
(
  input  wire logic [1:0]       mode_i,
  input  wire logic [ADC_W-1:0] pre_adc_i,
  input  wire logic [ADC_W-1:0] vcc_adc_i,
  input  wire logic [ADC_W-1:0] vbb_adc_i,
  output logic                  panic_o,
  output logic                  low_err_o,
  output logic                  off_err_o
);

  function automatic eps_vclass_e classify(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi);
    if (v > hi) begin
      return EPS_V_HIGH;
    end else if (v < lo) begin
      return EPS_V_LOW;
    end
    return EPS_V_OK;
  endfunction

  logic [7:0]  pre_t;
  logic [7:0]  vcc_t;
  logic [7:0]  vbb_t;
  eps_vclass_e pre_c;
  eps_vclass_e vcc_c;
  eps_vclass_e vbb_c;

  // Only the top byte is used; the converter tolerance makes the rest noise.
  assign pre_t = pre_adc_i[ADC_W-1 -: 8];
  assign vcc_t = vcc_adc_i[ADC_W-1 -: 8];
  assign vbb_t = vbb_adc_i[ADC_W-1 -: 8];

  always_comb begin
    pre_c     = EPS_V_OK;
    vcc_c     = EPS_V_OK;
    vbb_c     = EPS_V_OK;
    panic_o   = 1'b0;
    low_err_o = 1'b0;
    off_err_o = 1'b0;
    unique case (eps_mode_e'(mode_i))
      EPS_MODE_READ: begin
        pre_c = classify(pre_t, PRE_LV_MIN, PRE_LV_MAX);
        vcc_c = classify(vcc_t, LV_MIN, LV_MAX);
        vbb_c = classify(vbb_t, LV_MIN, LV_MAX);
        panic_o   = (pre_c == EPS_V_HIGH);
        low_err_o = (pre_c == EPS_V_LOW) || (vcc_c != EPS_V_OK)
                    || (vbb_c != EPS_V_OK);
      end
      EPS_MODE_PROG: begin
        pre_c = classify(pre_t, PRE_HV_MIN, PRE_HV_MAX);
        vcc_c = classify(vcc_t, VCC_HV_MIN, VCC_HV_MAX);
        vbb_c = classify(vbb_t, VBB_HV_MIN, VBB_HV_MAX);
        panic_o = (pre_c == EPS_V_HIGH) || (vcc_c == EPS_V_HIGH)
                  || (vbb_c == EPS_V_HIGH);
        low_err_o = !panic_o && ((vcc_c == EPS_V_LOW) || (vbb_c == EPS_V_LOW)
                    || (pre_c == EPS_V_LOW));
      end
      EPS_MODE_DONE: begin
        off_err_o = (pre_t > OFF_MAX) || (vcc_t > OFF_MAX)
                    || (vbb_t > OFF_MAX);
      end
      EPS_MODE_IDLE: begin
        panic_o = 1'b0;
      end
    endcase
  end

endmodule

// ### testbench/eps_supervisor_props.sv
/*
  Port checker for the programmer supervisor.
  Assumes it is bound to eps_supervisor and sees only that module's ports.
*/
module eps_supervisor_props
  import eps_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             srst_i,
  input wire logic             device_type_command_i,
  input wire logic             device_type_i,
  input wire logic             pass_count_command_i,
  input wire logic [7:0]       pass_count_i,
  input wire logic             socket_program_command_i,
  input wire logic             err_abort_i,
  input wire logic             download_end_i,
  input wire logic [ADC_W-1:0] pre_adc_i,
  input wire logic [ADC_W-1:0] vcc_adc_i,
  input wire logic [ADC_W-1:0] vbb_adc_i,
  input wire logic             device_older_o,
  input wire logic [7:0]       pass_setting_o,
  input wire logic [7:0]       erased_value_o,
  input wire logic             socket_power_o,
  input wire logic             high_voltage_o,
  input wire logic             confirm_request_o,
  input wire logic             error_pending_o,
  input wire logic             panic_o,
  input wire logic             download_report_o,
  input wire logic             busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pre_t;
  logic [7:0] vcc_t;
  logic [7:0] vbb_t;
  logic       hv_live;
  assign pre_t   = pre_adc_i[ADC_W-1:ADC_W-8];
  assign vcc_t   = vcc_adc_i[ADC_W-1:ADC_W-8];
  assign vbb_t   = vbb_adc_i[ADC_W-1:ADC_W-8];
  // An open error holds supervision off, so it is excluded here.
  assign hv_live = high_voltage_o && !panic_o && !error_pending_o;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_hot;
    hv_live && (pre_t > PRE_HV_MAX || vcc_t > VCC_HV_MAX || vbb_t > VBB_HV_MAX);
  endsequence
  sequence s_in_window;
    hv_live && pre_t inside {[PRE_HV_MIN:PRE_HV_MAX]} && vbb_t inside {[VBB_HV_MIN:VBB_HV_MAX]}
      && vcc_t inside {[VCC_HV_MIN:VCC_HV_MAX]};
  endsequence
  sequence s_asked;
    confirm_request_o && !high_voltage_o;
  endsequence

  a_panic_supplies_off: assert property (panic_o |-> !socket_power_o && !high_voltage_o)
    else $error("supplies on during panic");
  a_panic_held: assert property (panic_o |=> panic_o)
    else $error("panic dropped");
  a_prog_high_panic: assert property (s_hot |=> panic_o)
    else $error("no panic on high");
  a_prog_window_ok: assert property (s_in_window |=> !panic_o && !error_pending_o)
    else $error("good supplies flagged");
  a_abort_power_off: assert property (error_pending_o && err_abort_i |-> ##[1:2] !socket_power_o)
    else $error("power on after abort");
  a_type_reload: assert property (device_type_command_i |=> device_older_o == $past(device_type_i)
    && pass_setting_o == ($past(device_type_i) ? LEGACY_PASSES : 8'h00))
    else $error("type reload missed");
  a_count_load: assert property (pass_count_command_i && !device_type_command_i
    |=> pass_setting_o == $past(pass_count_i))
    else $error("pass count not loaded");
  a_erased_by_type: assert property (erased_value_o == (device_older_o ? ERASED_OLD : ERASED_NEW))
    else $error("wrong erased value");
  a_report_follows: assert property (download_end_i |=> download_report_o)
    else $error("no download report");
  a_confirm_first: assert property (socket_program_command_i && !busy_o && !panic_o |=> s_asked)
    else $error("no confirmation");
endmodule

bind eps_supervisor eps_supervisor_props eps_supervisor_props_i (
  .clk_i, .srst_i, .device_type_command_i, .device_type_i, .pass_count_command_i,
  .pass_count_i, .socket_program_command_i, .err_abort_i, .download_end_i, .pre_adc_i,
  .vcc_adc_i, .vbb_adc_i, .device_older_o, .pass_setting_o, .erased_value_o,
  .socket_power_o, .high_voltage_o, .confirm_request_o, .error_pending_o, .panic_o,
  .download_report_o, .busy_o
);

// ### testbench/eps_socket_model.sv
/*
  Behavioural socket drivers and supply monitor facing the supervisor.
  Assumes the testbench selects a supply fault and the passes a part needs.
*/
module eps_socket_model
  import eps_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic [1:0]       fault_i,
  input  wire logic [7:0]       p_need_i,
  input  wire logic             socket_power_i,
  input  wire logic             high_voltage_i,
  input  wire logic             pass_start_i,
  input  wire logic             verify_start_i,
  output logic                  pass_done_o,
  output logic                  readback_ok_o,
  output logic                  verify_done_o,
  output logic                  verify_match_o,
  output logic [ADC_W-1:0]      pre_adc_o,
  output logic [ADC_W-1:0]      vcc_adc_o,
  output logic [ADC_W-1:0]      vbb_adc_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] pass_sr;
  logic [2:0] ver_sr;
  logic [7:0] n_done;
  logic [3:0] rd_cnt;
  logic       pwr_q;
  logic [7:0] pre_b;
  logic [7:0] vcc_b;
  logic [7:0] vbb_b;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pass_sr <= 3'h0;
      ver_sr  <= 3'h0;
      n_done  <= 8'h00;
      rd_cnt  <= 4'h0;
      pwr_q   <= 1'b0;
    end else begin
      pass_sr <= {pass_sr[1:0], pass_start_i};
      ver_sr  <= {ver_sr[1:0], verify_start_i};
      n_done  <= high_voltage_i ? n_done + {7'h00, pass_sr[2]} : 8'h00;
      pwr_q   <= socket_power_i;
      if (socket_power_i && !pwr_q && !high_voltage_i) begin
        rd_cnt <= 4'h8;
      end else if (rd_cnt != 4'h0) begin
        rd_cnt <= rd_cnt - 4'h1;
      end
    end
  end
  assign pass_done_o    = pass_sr[2];
  assign readback_ok_o  = (n_done >= p_need_i);
  // A read ends a fixed time after power comes up; the contents always match.
  assign verify_done_o  = ver_sr[2] || (rd_cnt == 4'h1);
  assign verify_match_o = verify_done_o;
  always_comb begin
    if (!socket_power_i) begin
      pre_b = (fault_i == 2'h3) ? 8'h02 : 8'h00;
      vcc_b = pre_b;
      vbb_b = pre_b;
    end else if (!high_voltage_i) begin
      pre_b = 8'h30;
      vcc_b = 8'h10;
      vbb_b = 8'h10;
    end else begin
      pre_b = 8'hE0;
      vcc_b = 8'h95;
      vbb_b = 8'hB8;
    end
    if (socket_power_i && fault_i == 2'h1) begin
      pre_b = 8'hF8;
    end
    if (socket_power_i && fault_i == 2'h2) begin
      pre_b = high_voltage_i ? 8'hC0 : 8'h10;
      vcc_b = high_voltage_i ? 8'h80 : 8'h08;
    end
  end
  // Low bits set so that only the upper eight bits may decide.
  assign pre_adc_o = {pre_b, 2'h3};
  assign vcc_adc_o = {vcc_b, 2'h3};
  assign vbb_adc_o = {vbb_b, 2'h3};
endmodule

// ### testbench/testbench.sv
/*
  Self-checking bench for the programmer supervisor.
  Assumes the socket model stands in for the drivers and supply monitor.
*/
module testbench
  import eps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic pc; logic v; logic [7:0] pv; logic older; logic [7:0] pass;
                  logic au; logic [7:0] pg;} eps_row_s;
  logic            clk_i, srst_i, page_auto_i, device_type_i;
  logic            pls [12];
  logic [7:0]      page_value_i, pass_count_i, upload_offset_i, p_need;
  logic [15:0]     record_addr_i;
  logic [1:0]      fault;
  wire             pass_done, readback_ok, verify_done, verify_match, rec_wr, report, older;
  wire             spower, hv, pstart, vstart, confirm, err_p, off_err, panic, match, done, busy;
  wire [ADC_W-1:0] pre_adc, vcc_adc, vbb_adc;
  wire [7:0]       acc_cnt, pass_set, erased, rec_off;
  wire [15:0]      up_addr;
  int              n_mismatch, tests_run, n_pass;
  eps_row_s        rows [4];

  eps_supervisor eps_supervisor_i (.clk_i(clk_i), .srst_i(srst_i),
    .page_select_command_i(pls[0]), .page_auto_i(page_auto_i), .page_value_i(page_value_i),
    .device_type_command_i(pls[1]), .device_type_i(device_type_i),
    .pass_count_command_i(pls[2]), .pass_count_i(pass_count_i),
    .socket_read_command_i(pls[3]), .socket_program_command_i(pls[4]),
    .confirm_yes_i(pls[5]), .confirm_no_i(pls[6]), .err_continue_i(pls[7]),
    .err_abort_i(pls[8]), .download_start_i(pls[9]), .record_valid_i(pls[10]),
    .record_addr_i(record_addr_i), .download_end_i(pls[11]), .upload_offset_i(upload_offset_i),
    .pass_done_i(pass_done), .readback_ok_i(readback_ok), .verify_done_i(verify_done),
    .verify_match_i(verify_match), .pre_adc_i(pre_adc), .vcc_adc_i(vcc_adc), .vbb_adc_i(vbb_adc),
    .record_write_o(rec_wr), .record_offset_o(rec_off), .accepted_count_o(acc_cnt),
    .download_report_o(report), .upload_addr_o(up_addr), .device_older_o(older),
    .pass_setting_o(pass_set), .erased_value_o(erased), .socket_power_o(spower),
    .high_voltage_o(hv), .pass_start_o(pstart), .verify_start_o(vstart),
    .confirm_request_o(confirm), .error_pending_o(err_p), .off_error_o(off_err),
    .panic_o(panic), .verify_match_o(match), .op_done_o(done), .busy_o(busy));
  eps_socket_model eps_socket_model_i (.clk_i(clk_i), .srst_i(srst_i), .fault_i(fault),
    .p_need_i(p_need), .socket_power_i(spower), .high_voltage_i(hv), .pass_start_i(pstart),
    .verify_start_i(vstart), .pass_done_o(pass_done), .readback_ok_o(readback_ok),
    .verify_done_o(verify_done), .verify_match_o(verify_match), .pre_adc_o(pre_adc),
    .vcc_adc_o(vcc_adc), .vbb_adc_o(vbb_adc));

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step;
    @(posedge clk_i);
    #2;
  endtask
  task automatic pulse(int b);
    pls[b] = 1'b1;
    step();
    pls[b] = 1'b0;
  endtask
  task automatic rec(logic [15:0] a, logic w);
    record_addr_i = a;
    pulse(10);
    chk("record write", rec_wr, w);
    if (w) chk("record offset", rec_off, a[7:0]);
    step();
  endtask
  task automatic wait_done;
    for (int i = 0; i < 400 && done !== 1'b1; i++) step();
    chk("op done", done, 1'b1);
  endtask
  task automatic prog(logic yes);
    n_pass = 0;
    pulse(4);
    chk("confirm request", confirm, 1'b1);
    pulse(yes ? 5 : 6);
  endtask
  task automatic give_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(negedge clk_i) if (pstart === 1'b1) n_pass++;
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    // The operator's usual fixed count of 32 passes is the second row.
    rows = '{'{1'b0, 1'b1, 8'h00, 1'b1, 8'h0A, 1'b0, 8'h13},
             '{1'b1, 1'b0, 8'h20, 1'b1, 8'h20, 1'b1, 8'h77},
             '{1'b0, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 8'hC4},
             '{1'b1, 1'b0, 8'h03, 1'b0, 8'h03, 1'b1, 8'h00}};
    foreach (pls[i]) pls[i] = 1'b0;
    {page_auto_i, device_type_i, page_value_i, pass_count_i} = 18'h0;
    {record_addr_i, fault, p_need, upload_offset_i} = {16'h0000, 2'h0, 8'h01, 8'h5A};
    srst_i = 1'b1;
    repeat (5) step();
    srst_i = 1'b0;
    chk("older", older, 1'b0);
    chk("pass setting", pass_set, 8'h00);
    chk("erased", erased, ERASED_NEW);
    chk("upload auto", up_addr, {PAGE_AUTO_UP, 8'h5A});
    foreach (rows[i]) begin
      {device_type_i, pass_count_i, page_auto_i, page_value_i} =
        {rows[i].v, rows[i].pv, rows[i].au, rows[i].pg};
      pulse(rows[i].pc ? 2 : 1);
      pulse(0);
      chk("older", older, rows[i].older);
      chk("pass setting", pass_set, rows[i].pass);
      chk("erased", erased, rows[i].older ? ERASED_OLD : ERASED_NEW);
      chk("upload", up_addr, {rows[i].au ? PAGE_AUTO_UP : rows[i].pg, 8'h5A});
    end
    prog(1'b1);
    wait_done();
    chk("fixed passes", n_pass[7:0], 8'h03);
    chk("verify match", match, 1'b1);
    chk("off error", off_err, 1'b0);
    pass_count_i = 8'h00;
    pulse(2);
    p_need = 8'h02;
    prog(1'b1);
    wait_done();
    chk("adaptive passes", n_pass[7:0], 8'h0A);
    prog(1'b0);
    repeat (4) step();
    chk("refused power", spower, 1'b0);
    pulse(9);
    rec(16'h1205, 1'b1);
    rec(16'h1306, 1'b0);
    rec(16'h1207, 1'b1);
    pulse(11);
    chk("report", report, 1'b1);
    chk("accepted", acc_cnt, 8'h02);
    {page_auto_i, page_value_i} = {1'b0, 8'h13};
    pulse(0);
    pulse(9);
    rec(16'h1205, 1'b0);
    rec(16'h1306, 1'b1);
    pulse(11);
    chk("accepted", acc_cnt, 8'h01);
    fault = 2'h3;
    pulse(3);
    wait_done();
    chk("residual", off_err, 1'b1);
    fault = 2'h2;
    pulse(3);
    for (int i = 0; i < 40 && err_p !== 1'b1; i++) step();
    chk("low error", err_p, 1'b1);
    chk("low panic", panic, 1'b0);
    fault = 2'h0;
    pulse(8);
    wait_done();
    chk("abort power", spower, 1'b0);
    fault = 2'h1;
    prog(1'b1);
    for (int i = 0; i < 40 && panic !== 1'b1; i++) step();
    chk("panic", panic, 1'b1);
    {fault, device_type_i} = 3'h1;
    pulse(1);
    pulse(3);
    step();
    chk("read refused", spower, 1'b0);
    srst_i = 1'b1;
    step();
    srst_i = 1'b0;
    chk("panic cleared", panic, 1'b0);
    chk("older", older, 1'b0);
    chk("auto page", up_addr, {PAGE_AUTO_UP, 8'h5A});
    give_verdict();
  end
endmodule
